// ===== rtl/acr_pkg.sv
// Constants for the continuous-read result path
`default_nettype none
package acr_pkg;
   localparam int          WORD_W          = 24;
   localparam logic [7:0]  CMD_ENTER_CREAD = 8'h5C;
   localparam logic [7:0]  CMD_EXIT_CREAD  = 8'h58;
   localparam int          ONES_RESET_LEN  = 32;
   localparam logic [5:0]  ONES_CNT_LAST   = 6'h1F;
   localparam logic [4:0]  WORD_LEN_16     = 5'h10;
   localparam logic [4:0]  WORD_LEN_24     = 5'h18;
   localparam logic [2:0]  GAIN_BUF_FORCE  = 3'h2;
   localparam logic [2:0]  GAIN_INAMP_MIN  = 3'h2;
   localparam logic        RST_BUFFER_EN   = 1'b1;
   localparam logic [2:0]  RST_GAIN        = 3'h7;
   localparam logic        RST_UNIPOLAR    = 1'b0;
   localparam logic        RST_BURNOUT     = 1'b0;
   localparam int          CLK_HZ          = 50_000_000;
   localparam int          POST_RESET_US   = 500;
   localparam int          POST_RESET_CYC  = POST_RESET_US * (CLK_HZ / 1_000_000);
endpackage
`default_nettype wire

// ===== rtl/acr_sync.sv
// Two-flop synchroniser for a single level
`default_nettype none
module acr_sync (
   input  wire logic clk,    // Destination clock
   input  wire logic reset,  // Synchronous reset, high
   input  wire logic d,      // Asynchronous level
   output logic      q       // Synchronised level
);
   logic meta;
   always_ff @(posedge clk) begin
      if (reset) begin
         meta <= 1'b0;
         q    <= 1'b0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule
`default_nettype wire

// ===== rtl/acr_core.sv
// Continuous-read serial output, command watch and result coding
`default_nettype none
// Behaviour
// R1 - Command 0x5C enters continuous read mode
// R2 - Host keeps converter in continuous conversion
// R3 - Host clocks out whole word after ready
// R4 - Ready high after readout until next result
// R5 - Each word shifts out only once
// R6 - Unread word replaced at next completion
// R7 - Command 0x58 exits while ready low
// R8 - Thirty-two ones on data in reset all; code acts on them only in continuous read mode
// R9 - Host holds data in low between commands
// R10 - Buffer enable routes input through buffer
// R11 - Gains above two force buffer on
// R12 - Gain four or more enables in-amp
// R13 - Three-bit gain code selects eight gains
// R14 - Unipolar bit picks range and coding
// R15 - Unipolar result is straight binary
// R16 - Bipolar result is offset binary
// R17 - Word width sixteen or twenty-four bits
// R18 - One bit switches both burnout currents
// R19 - Missing reference clamps result to ones
// R20 - Ready low on new word when selected
// R21 - Ones reset restores defaults, host waits
// R22 - Gain equals two to the code
// R23 - After exit await communication write
module acr_core
   import acr_pkg::*;
(
   input  wire logic                core_clk,          // Modulator side clock
   input  wire logic                reset,             // Synchronous reset, high
   input  wire logic                serial_clk,        // Host serial clock
   input  wire logic                chip_select_n,     // Chip select, low active
   input  wire logic                serial_data_in,    // Host data in, sampled on rise
   output logic                     data_out_ready,    // Data out, low also flags ready
   input  wire logic                wide_variant,      // 1: 24-bit word, 0: 16-bit word
   input  wire logic                conv_done,         // One-cycle pulse, result valid
   input  wire logic [WORD_W-1:0]   conv_raw,          // Two's complement modulator result
   input  wire logic                ref_missing,       // Reference absent
   input  wire logic                cfg_write,         // Pulse: load config ports below
   input  wire logic                input_buffer_enable,// Buffer request
   input  wire logic [2:0]          gain_select,       // Gain code
   input  wire logic                unipolar_select,   // 1 unipolar, 0 bipolar
   input  wire logic                burnout_enable,    // Burnout current enable
   output logic                     buffer_on,         // Buffer in path
   output logic                     inamp_on,          // In-amp in path
   output logic [7:0]               gain_value,        // Effective gain
   output logic                     burnout_on,        // Both test currents on
   output logic                     cread_active,      // Continuous read mode
   output logic                     soft_reset         // Ones reset pulse, core domain
);
   import acr_pkg::*;

   // Core domain state
   typedef struct packed {
      logic              cfg_buf;
      logic [2:0]        cfg_gain;
      logic              cfg_uni;
      logic              cfg_bo;
      logic [WORD_W-1:0] word;
      logic              word_tgl;
      logic              seen_taken;
      logic              rst_seen;
   } acr_core_t;
   acr_core_t s, next_s;

   // Link domain state
   typedef struct packed {
      logic              cread;
      logic [7:0]        cmd_sr;
      logic [2:0]        cmd_bits;
      logic [5:0]        ones;
      logic [WORD_W-1:0] shreg;
      logic [4:0]        left;
      logic              rdy_n;
      logic              seen_tgl;
      logic              taken_tgl;
      logic              rst_tgl;
      logic              dout;
   } acr_link_t;
   acr_link_t l, next_l;

   logic              tgl_sync;
   logic              taken_sync;
   logic              rst_sync;
   logic [WORD_W-1:0] coded;
   logic [WORD_W-1:0] word_hold;

   // Result coding; raw is two's complement, bipolar maps to offset binary
   always_comb begin
      if (s.cfg_uni)
         coded = conv_raw[WORD_W-1] ? '0 : {conv_raw[WORD_W-2:0], 1'b0};  // see R15
      else
         coded = {~conv_raw[WORD_W-1], conv_raw[WORD_W-2:0]};             // see R16
      if (ref_missing)
         coded = '1;                                                       // see R19
      if (!wide_variant)
         coded = {coded[WORD_W-1:WORD_W-16], 8'h00};                       // see R17
   end

   always_comb begin
      next_s = s;
      if (cfg_write) begin
         next_s.cfg_buf  = input_buffer_enable;
         next_s.cfg_gain = gain_select;
         next_s.cfg_uni  = unipolar_select;                                // see R14
         next_s.cfg_bo   = burnout_enable;
      end
      if (conv_done) begin
         // Toggle announces a new word; word holds until next completion
         next_s.word     = coded;                                          // see R6
         next_s.word_tgl = ~s.word_tgl;
      end
      next_s.seen_taken = taken_sync;
      next_s.rst_seen   = rst_sync;
   end

   always_ff @(posedge core_clk) begin
      if (reset || soft_reset) begin
         s          <= '0;
         s.cfg_buf  <= RST_BUFFER_EN;                                      // see R21
         s.cfg_gain <= RST_GAIN;
         s.cfg_uni  <= RST_UNIPOLAR;
         s.cfg_bo   <= RST_BURNOUT;
         s.rst_seen <= rst_sync;
      end else begin
         s <= next_s;
      end
   end

   assign soft_reset = (rst_sync != s.rst_seen);                           // see R8
   assign buffer_on  = s.cfg_buf || (s.cfg_gain > GAIN_BUF_FORCE - 3'h1);  // see R10 see R11
   assign inamp_on   = (s.cfg_gain >= GAIN_INAMP_MIN);                     // see R12
   assign gain_value = 8'h01 << s.cfg_gain;                                // see R13 see R22
   assign burnout_on = s.cfg_bo;                                           // see R18

   // Word is stable long before its toggle crosses, so a plain copy is safe
   assign word_hold = s.word;

   acr_sync u_tgl (
      .clk   (serial_clk),
      .reset (reset),
      .d     (s.word_tgl),
      .q     (tgl_sync)
   );
   acr_sync u_taken (
      .clk   (core_clk),
      .reset (reset),
      .d     (l.taken_tgl),
      .q     (taken_sync)
   );
   acr_sync u_rst (
      .clk   (core_clk),
      .reset (reset),
      .d     (l.rst_tgl),
      .q     (rst_sync)
   );
   acr_sync u_cread (
      .clk   (core_clk),
      .reset (reset),
      .d     (l.cread),
      .q     (cread_active)
   );

   // Link side: data in sampled on serial clock rise; serial clock stops between frames
   always_comb begin
      next_l = l;
      next_l.dout = l.dout;
      if (!chip_select_n) begin
         next_l.cmd_sr = {l.cmd_sr[6:0], serial_data_in};
         next_l.cmd_bits = l.cmd_bits + 3'h1;
         next_l.ones = serial_data_in ? l.ones + 6'h01 : 6'h00;
         if (l.cmd_bits == 3'h7) begin
            if (!l.cread && {l.cmd_sr[6:0], serial_data_in} == CMD_ENTER_CREAD)
               next_l.cread = 1'b1;                                        // see R1
            else if (l.cread && !l.rdy_n
                     && {l.cmd_sr[6:0], serial_data_in} == CMD_EXIT_CREAD) begin
               next_l.cread = 1'b0;                                        // see R7 see R23
               next_l.rdy_n = 1'b1;
            end
         end
         // Idle low bits resync framing; a leading zero of a command counts as its first bit
         if (l.cread && l.cmd_sr == 8'h00 && !serial_data_in)
            next_l.cmd_bits = 3'h1;                                        // see R9
         if (l.cread && !l.rdy_n) begin
            if (l.left != 5'h00) begin
               next_l.shreg = {l.shreg[WORD_W-2:0], 1'b0};
               next_l.dout  = l.shreg[WORD_W-1];
               next_l.left  = l.left - 5'h01;
            end else begin
               // Last bit stands a full clock before the line is released
               next_l.rdy_n     = 1'b1;                                    // see R4 see R5
               next_l.taken_tgl = ~l.taken_tgl;
            end
         end
         if (l.cread && l.ones == ONES_CNT_LAST && serial_data_in) begin
            next_l.rst_tgl = ~l.rst_tgl;                                   // see R8 see R21
            next_l.cread   = 1'b0;
            next_l.ones    = 6'h00;
            next_l.cmd_bits = 3'h0;
            // Link side returns to its idle state too
            next_l.rdy_n   = 1'b1;
            next_l.left    = 5'h00;
         end
      end
      if (tgl_sync != l.seen_tgl) begin
         // New completion discards any partial readout
         next_l.seen_tgl = tgl_sync;
         next_l.shreg    = word_hold;                                      // see R6
         next_l.left     = wide_variant ? WORD_LEN_24 : WORD_LEN_16;       // see R17
         next_l.rdy_n    = 1'b0;
      end
   end

   always_ff @(posedge serial_clk) begin
      if (reset) begin
         l       <= '0;
         l.rdy_n <= 1'b1;
         l.dout  <= 1'b1;
      end else begin
         l <= next_l;
      end
   end

   // Output: ready low while a word waits, then data bits as clocked
   always_comb begin
      if (chip_select_n)
         data_out_ready = 1'b1;                                            // see R20
      else if (l.cread && !l.rdy_n && l.left != (wide_variant ? WORD_LEN_24 : WORD_LEN_16))
         data_out_ready = l.dout;
      else
         data_out_ready = l.rdy_n;                                         // see R20
   end

   // Serial domain checks
   sequence ones_full_s;
      !chip_select_n && l.cread && l.ones == ONES_CNT_LAST && serial_data_in;
   endsequence

   sequence exit_byte_s;
      !chip_select_n && l.cread && !l.rdy_n && l.cmd_bits == 3'h7 && tgl_sync == l.seen_tgl
      && {l.cmd_sr[6:0], serial_data_in} == CMD_EXIT_CREAD;
   endsequence

   sequence word_drained_s;
      !chip_select_n && l.cread && !l.rdy_n && l.left == 5'h00 && tgl_sync == l.seen_tgl;
   endsequence

   sequence new_word_s;
      tgl_sync != l.seen_tgl;
   endsequence

   ones_reset_a: assert property (@(posedge serial_clk) disable iff (reset)
      ones_full_s |=> (l.rst_tgl != $past(l.rst_tgl) && !l.cread))
      else $error("ones reset not taken");                                 // see R8
   exit_cmd_a: assert property (@(posedge serial_clk) disable iff (reset)
      exit_byte_s |=> !l.cread && l.rdy_n)
      else $error("exit command missed");                                  // see R7
   enter_cmd_a: assert property (@(posedge serial_clk) disable iff (reset)
      (!chip_select_n && !l.cread && l.cmd_bits == 3'h7
       && {l.cmd_sr[6:0], serial_data_in} == CMD_ENTER_CREAD) |=> l.cread)
      else $error("enter command missed");                                 // see R1
   ready_high_a: assert property (@(posedge serial_clk) disable iff (reset)
      word_drained_s |=> l.rdy_n)
      else $error("ready not raised after word");                          // see R4
   taken_once_a: assert property (@(posedge serial_clk) disable iff (reset)
      word_drained_s |=> l.taken_tgl != $past(l.taken_tgl))
      else $error("readout not reported");                                 // see R5
   read_once_a: assert property (@(posedge serial_clk) disable iff (reset)
      (l.rdy_n && tgl_sync == l.seen_tgl) |=> l.rdy_n)
      else $error("ready fell without new word");                          // see R5
   replace_a: assert property (@(posedge serial_clk) disable iff (reset)
      new_word_s |=> !l.rdy_n && l.shreg == $past(word_hold))
      else $error("new word not loaded");                                  // see R6

   // Core domain checks, then one serial domain deselect check
   gain_map_a: assert property (@(posedge core_clk) disable iff (reset)
      gain_value == (8'h01 << s.cfg_gain) && inamp_on == (gain_value >= 8'h04))
      else $error("gain map wrong");                                       // see R12
   buffer_force_a: assert property (@(posedge core_clk) disable iff (reset)
      (gain_value > 8'h02) |-> buffer_on)
      else $error("buffer not forced");                                    // see R11
   buffer_req_a: assert property (@(posedge core_clk) disable iff (reset)
      s.cfg_buf |-> buffer_on)
      else $error("buffer request ignored");                               // see R10
   soft_defaults_a: assert property (@(posedge core_clk) disable iff (reset)
      soft_reset |=> s.cfg_gain == RST_GAIN && s.cfg_buf == RST_BUFFER_EN
                     && s.cfg_uni == RST_UNIPOLAR && s.cfg_bo == RST_BURNOUT)
      else $error("soft reset left config");                               // see R21
   clamp_ones_a: assert property (@(posedge core_clk) disable iff (reset || soft_reset)
      (conv_done && ref_missing) |=> s.word[WORD_W-1:WORD_W-16] == 16'hFFFF)
      else $error("missing reference not clamped");                        // see R19
   deselect_a: assert property (@(posedge serial_clk) disable iff (reset)
      chip_select_n |-> data_out_ready)
      else $error("output low while deselected");                          // see R20
endmodule
`default_nettype wire

// ===== dv/acr_host.sv
// Host controller model driving the serial link
`default_nettype none
module acr_host (
   output var logic serial_clk,     // Serial clock, idles high
   output var logic chip_select_n,  // Chip select, low unless select raises it
   output var logic serial_data_in, // Command data to device
   input  wire logic data_out_ready // Ready and read data
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      serial_clk = 1'b1;
      chip_select_n = 1'b0;
      serial_data_in = 1'b0;
   end
   // Data changes on the fall, device samples on the rise
   task automatic tick(input logic d);
      serial_clk = 1'b0;
      serial_data_in = d;
      #40;
      serial_clk = 1'b1;
      #40;
   endtask
   task automatic select(input logic n);
      chip_select_n = n;
   endtask
   task automatic send_byte(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         tick(b[i]);
      end
      serial_data_in = 1'b0;
   endtask
   task automatic ones(input int n);
      repeat (n) tick(1'b1);
      serial_data_in = 1'b0;
   endtask
   // Clock runs only while waiting, so the crossing can finish
   task automatic wait_ready(output logic ok);
      ok = 1'b0;
      for (int i = 0; i < 64 && !ok; i++) begin
         if (data_out_ready === 1'b0) ok = 1'b1;
         else tick(1'b0);
      end
   endtask
   task automatic read_word(input int n, output logic [23:0] w);
      w = 24'h000000;
      repeat (n) begin
         tick(1'b0);
         w = {w[22:0], data_out_ready};
      end
   endtask
endmodule
`default_nettype wire

// ===== dv/test_adc_continuous_read_and_coding.sv
// Self-checking bench for the continuous-read result path
`default_nettype none
module test_adc_continuous_read_and_coding import acr_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, reset, serial_clk, chip_select_n, serial_data_in, data_out_ready;
   logic wide_variant, conv_done, ref_missing, cfg_write, input_buffer_enable;
   logic unipolar_select, burnout_enable, buffer_on, inamp_on, burnout_on;
   logic cread_active, soft_reset, ok;
   logic [WORD_W-1:0] conv_raw;
   logic [2:0]        gain_select;
   logic [7:0]        gain_value;
   logic [23:0]       w;
   int                failures = 0;
   int                n_compared = 0;
   int                n_soft = 0;

   acr_core dut (.core_clk(core_clk), .reset(reset), .serial_clk(serial_clk),
      .chip_select_n(chip_select_n), .serial_data_in(serial_data_in),
      .data_out_ready(data_out_ready), .wide_variant(wide_variant), .conv_done(conv_done),
      .conv_raw(conv_raw), .ref_missing(ref_missing), .cfg_write(cfg_write),
      .input_buffer_enable(input_buffer_enable), .gain_select(gain_select),
      .unipolar_select(unipolar_select), .burnout_enable(burnout_enable),
      .buffer_on(buffer_on), .inamp_on(inamp_on), .gain_value(gain_value),
      .burnout_on(burnout_on), .cread_active(cread_active), .soft_reset(soft_reset));
   acr_host host (.serial_clk(serial_clk), .chip_select_n(chip_select_n),
      .serial_data_in(serial_data_in), .data_out_ready(data_out_ready));

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   always @(posedge core_clk) if (soft_reset === 1'b1) n_soft <= n_soft + 1;

   task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
      #2;
   endtask
   task automatic cfg(input logic b, input logic [2:0] g, input logic u, input logic o);
      cyc(1);
      {input_buffer_enable, gain_select, unipolar_select, burnout_enable} = {b, g, u, o};
      cfg_write = 1'b1;
      cyc(1);
      cfg_write = 1'b0;
   endtask
   task automatic conv(input logic [23:0] raw);
      cyc(1);
      conv_raw = raw;
      conv_done = 1'b1;
      cyc(1);
      conv_done = 1'b0;
   endtask
   task automatic read_conv(input logic [23:0] raw, input int n, input logic [23:0] exp);
      conv(raw);
      host.wait_ready(ok);
      check("ready", ok, 1);
      host.read_word(n, w);
      check("word", w, exp);
      host.tick(1'b0);
      check("ready_high", data_out_ready, 1);
   endtask
   task automatic t_config();
      check("default_gain", gain_value, 8'h80);
      check("default_buf", {buffer_on, inamp_on, burnout_on, cread_active}, 4'hC);
      for (int k = 0; k < 8; k++) begin
         cfg(1'b0, k[2:0], 1'b0, k[0]);
         check("gain", gain_value, 8'h01 << k);
         check("buffer", buffer_on, k >= 2);
         check("inamp", inamp_on, k >= 2);
         check("burnout", burnout_on, k[0]);
      end
      cfg(1'b1, 3'h0, 1'b0, 1'b0);
      check("buffer_req", buffer_on, 1);
   endtask
   task automatic t_stream();
      host.send_byte(CMD_ENTER_CREAD);
      cyc(4);
      check("enter", cread_active, 1);
      read_conv(24'h123456, 24, 24'h923456);
      host.read_word(24, w);
      check("reread", w, 24'hFFFFFF);
      conv(24'h7FFFFF);
      host.wait_ready(ok);
      host.read_word(8, w);
      read_conv(24'h800000, 24, 24'h000000);
      wide_variant = 1'b0;
      ref_missing = 1'b1;
      read_conv(24'h000000, 16, 24'h00FFFF);
      ref_missing = 1'b0;
      read_conv(24'hFFFFFF, 16, 24'h007FFF);
      wide_variant = 1'b1;
      cfg(1'b1, 3'h7, 1'b1, 1'b0);
      read_conv(24'h000000, 24, 24'h000000);
      read_conv(24'h400000, 24, 24'h800000);
   endtask
   task automatic t_exit_and_ones();
      int base;
      conv(24'h123456);
      host.wait_ready(ok);
      host.select(1'b1);
      host.tick(1'b0);
      check("deselect", data_out_ready, 1);
      host.select(1'b0);
      #1;
      check("reselect", data_out_ready, 0);
      host.send_byte(CMD_EXIT_CREAD);
      check("exit_ready", data_out_ready, 1);
      cyc(4);
      check("exit", cread_active, 0);
      host.send_byte(CMD_ENTER_CREAD);
      cfg(1'b0, 3'h0, 1'b1, 1'b1);
      base = n_soft;
      host.ones(31);
      host.tick(1'b0);
      cyc(8);
      check("no_reset", n_soft - base, 0);
      host.ones(32);
      cyc(8);
      check("ones_reset", n_soft - base, 1);
      check("reset_cfg", {gain_value, buffer_on, burnout_on, cread_active}, 11'h404);
      cyc(POST_RESET_CYC);
   endtask

   initial begin
      {reset, wide_variant, conv_done, ref_missing, cfg_write} = 5'b10000;
      {input_buffer_enable, gain_select, unipolar_select, burnout_enable} = 6'h00;
      conv_raw = 24'h000000;
      wide_variant = 1'b1;
      #7;
      fork
         cyc(10);
         host.read_word(4, w);
      join
      reset = 1'b0;
      t_config();
      t_stream();
      t_exit_and_ones();
      conclude();
   end
   initial begin
      #1_500_000;
      failures++;
      conclude();
   end
endmodule
`default_nettype wire
